// File: hw/clie_pkg.sv
// Purpose: Shared constants for the character display instruction engine.
// Assumes: 200 MHz sys_clk; Avalon-MM slave with 32-bit data.
// Notes: Offsets, instruction field positions, text map limits and the busy timing count live here.
`default_nettype none
package clie_pkg;
	// Avalon byte offsets: instruction/status word and data word
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_DATA = 3'h4;

	// Instruction field positions
	localparam int B_SC = 3;     // Shift: display (1) or cursor (0)
	localparam int B_RL = 2;     // Shift: right (1) or left (0)
	localparam int B_WIDTH = 4;  // Function: 8-bit bus when high
	localparam int B_LINES = 3;  // Function: two lines when high
	localparam int B_FONT = 2;   // Function: 5x11 cell when high
	localparam int B_INC = 1;    // Entry: increment when high
	localparam int B_SCROLL = 0; // Entry: scroll on text writes

	// Text memory address map
	localparam logic [6:0] TXT_ONE_END = 7'h4F;
	localparam logic [6:0] TXT_L1_END = 7'h27;
	localparam logic [6:0] TXT_L2_BASE = 7'h40;
	localparam logic [6:0] TXT_L2_END = 7'h67;
	localparam logic [6:0] LINE_LEN = 7'h28;
	localparam logic [6:0] TXT_DEPTH = 7'h50;
	localparam int GLY_DEPTH = 64;
	localparam logic [7:0] SPACE_CODE = 8'h20;

	// Busy time of one instruction, least time rounded up to cycles
	localparam int CNT_W = 13;
	localparam int BUSY_TIME_NS = 38000;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int BUSY_CYCLES =
		(BUSY_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Busy sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} clie_state_t;
endpackage
`default_nettype wire

// File: hw/clie_top.sv
// Purpose: Instruction engine of a character display controller.
// Assumes: Host reaches it over Avalon-MM; refresh logic on sys_clk.
// Notes: Offset 0x0 is instruction write / status read, 0x4 is data.
// Notes on behaviour
// - Cursor shift steps pointer one place
// - Display shift leaves pointer unchanged
// - Two-line cursor wraps past fortieth place
// - Display shift moves all lines, no memory
// - Width bit picks 8-bit or 4-bit transfers
// - 4-bit mode pairs two nibbles per byte
// - Lines bit picks one or two lines
// - Font bit picks 5x8 or 5x11 cell
// - Glyph address loads six bits, selects glyph
// - Text address loads seven bits, selects text
// - One-line text addresses run 00H to 4FH
// - Two-line: 00H-27H and 40H-67H
// - Status read gives busy and pointer
// - Data write stores into selected memory
// - Data write steps pointer by entry direction
// - First read without address is invalid
// - Address or cursor shift prefetches byte; the code skips it on a cursor shift in glyph memory
// - Data read steps pointer by entry direction
// - Read after write returns prefetched data
// - Entry bit sets step direction, glyph too
// - Scroll bit shifts display on text writes
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module clie_top #(
	parameter logic [clie_pkg::CNT_W-1:0] busy_cycles =
		clie_pkg::CNT_W'(clie_pkg::BUSY_CYCLES)
) (
	input wire logic sys_clk,                // System clock
	input wire logic sys_rst,                // Synchronous reset
	input wire logic [2:0] avs_address,      // Byte address
	input wire logic avs_read,               // Read request
	input wire logic avs_write,              // Write request
	input wire logic [3:0] avs_byteenable,   // Byte lanes
	input wire logic [31:0] avs_writedata,   // Write data
	output logic [31:0] avs_readdata,        // Read data
	output logic avs_waitrequest,            // Stall
	input wire logic [6:0] refresh_text_addr, // Refresh text address
	input wire logic [7:0] refresh_code,     // Refresh character code
	input wire logic [2:0] refresh_row,      // Refresh glyph row
	output logic [7:0] refresh_char,         // Text byte, one cycle late
	output logic [4:0] refresh_pixels,       // Glyph row, one cycle late
	output logic bus_width_select,           // 1: 8-bit, 0: 4-bit
	output logic cfg_two_line,               // Two-line display
	output logic cfg_font_tall,              // 5x11 cell
	output logic entry_increment,            // Step direction up
	output logic write_scroll_enable,        // Scroll on text writes
	output logic [6:0] disp_offset,          // Display shift position
	output logic [6:0] address_pointer,      // Address counter
	output logic busy_indicator              // Internal operation runs
);
	// Next address for a step, wrapping inside the valid map
	function automatic logic [6:0] clie_step(input logic [6:0] a,
		input logic up, input logic two, input logic gly);
		logic [6:0] r;
		r = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
		if (gly) begin
			r = {1'b0, r[5:0]};
		end else if (two) begin
			if (up && a == clie_pkg::TXT_L1_END) begin
				r = clie_pkg::TXT_L2_BASE;
			end else if (up && a == clie_pkg::TXT_L2_END) begin
				r = 7'h00;
			end else if (!up && a == clie_pkg::TXT_L2_BASE) begin
				r = clie_pkg::TXT_L1_END;
			end else if (!up && a == 7'h00) begin
				r = clie_pkg::TXT_L2_END;
			end
		end else begin
			if (up && a == clie_pkg::TXT_ONE_END) begin
				r = 7'h00;
			end else if (!up && a == 7'h00) begin
				r = clie_pkg::TXT_ONE_END;
			end
		end
		return r;
	endfunction

	// Text address to storage index; second line follows the first
	function automatic logic [6:0] clie_tidx(input logic [6:0] a,
		input logic two);
		logic [6:0] r;
		r = a;
		if (two && a[6]) begin
			r = 7'(clie_pkg::LINE_LEN + {1'b0, a[5:0]});
		end else if (two) begin
			r = {1'b0, a[5:0]};
		end
		return r;
	endfunction

	// Display offset rotation; left shift advances the offset
	function automatic logic [6:0] clie_rot(input logic [6:0] o,
		input logic left, input logic two);
		logic [6:0] last;
		logic [6:0] r;
		last = two ? 7'(clie_pkg::LINE_LEN - 7'h01)
			: 7'(clie_pkg::TXT_DEPTH - 7'h01);
		if (left) begin
			r = (o >= last) ? 7'h00 : 7'(o + 7'h01);
		end else begin
			r = (o == 7'h00) ? last : 7'(o - 7'h01);
		end
		return r;
	endfunction

	logic [7:0] text_mem [0:clie_pkg::TXT_DEPTH-1];
	logic [7:0] glyph_mem [0:clie_pkg::GLY_DEPTH-1];
	logic glyph_sel;
	logic nib_second;
	logic [3:0] hi_nib;
	logic [3:0] hold_lo;
	logic [7:0] out_data;
	clie_pkg::clie_state_t state;
	logic [clie_pkg::CNT_W-1:0] busy_cnt;

	logic mapped, is_data, full_xfer, acc, ex_wr, ex_rd, ins, dwr;
	logic [7:0] wbyte, rbyte;
	logic op_text, op_glyph, op_func, op_shift, op_entry, op_home;
	logic op_clear, cursor_move, disp_move, step_up, scroll_wr;
	logic [6:0] stepped, next_ptr, wr_idx, pf_idx;
	logic next_glyph;
	logic [7:0] pf_byte;

	// Access qualification; only the second nibble of a pair acts
	assign mapped = (avs_address == clie_pkg::REG_CTRL)
		|| (avs_address == clie_pkg::REG_DATA);
	assign is_data = (avs_address == clie_pkg::REG_DATA);
	assign acc = (avs_read || avs_write) && !avs_waitrequest;
	assign full_xfer = bus_width_select || nib_second;
	assign ex_wr = acc && avs_write && avs_byteenable[0] && mapped
		&& full_xfer;
	assign ex_rd = acc && avs_read && is_data && full_xfer;
	assign wbyte = bus_width_select ? avs_writedata[7:0]
		: {hi_nib, avs_writedata[7:4]};
	assign ins = ex_wr && !is_data;
	assign dwr = ex_wr && is_data;

	// Class from the highest set bit of the instruction byte
	assign op_text = ins && wbyte[7];
	assign op_glyph = ins && wbyte[7:6] == 2'h1;
	assign op_func = ins && wbyte[7:5] == 3'h1;
	assign op_shift = ins && wbyte[7:4] == 4'h1;
	assign op_entry = ins && wbyte[7:2] == 6'h01;
	assign op_home = ins && wbyte[7:1] == 7'h01;
	assign op_clear = ins && wbyte == 8'h01;
	assign cursor_move = op_shift && !wbyte[clie_pkg::B_SC];
	assign disp_move = op_shift && wbyte[clie_pkg::B_SC];

	// Step direction: shift bit for cursor moves, entry mode otherwise
	assign step_up = cursor_move ? wbyte[clie_pkg::B_RL]
		: entry_increment;
	assign stepped = clie_step(address_pointer, step_up, cfg_two_line,
		glyph_sel);
	assign scroll_wr = dwr && !glyph_sel && write_scroll_enable;

	// Pointer and target after this cycle's operation
	always_comb begin
		next_ptr = address_pointer;
		next_glyph = glyph_sel;
		if (op_text) begin
			next_ptr = wbyte[6:0];
			next_glyph = 1'b0;
		end else if (op_glyph) begin
			next_ptr = {1'b0, wbyte[5:0]};
			next_glyph = 1'b1;
		end else if (op_home || op_clear) begin
			next_ptr = 7'h00;
			next_glyph = 1'b0;
		end else if (cursor_move || dwr || ex_rd) begin
			next_ptr = stepped;
		end
	end

	// Byte the next read will return, fetched from the new location
	assign pf_idx = clie_tidx(next_ptr, cfg_two_line);
	assign wr_idx = clie_tidx(address_pointer, cfg_two_line);
	always_comb begin
		pf_byte = 8'h00;
		if (next_glyph) begin
			pf_byte = glyph_mem[next_ptr[5:0]];
		end else if (pf_idx < clie_pkg::TXT_DEPTH) begin
			pf_byte = text_mem[pf_idx];
		end
	end
	assign rbyte = !mapped ? 8'h00 : is_data ? out_data
		: {busy_indicator, address_pointer};

	// Bus handshake: every access answers one cycle after it is seen
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write)
				&& avs_waitrequest);
		end
	end

	// Read data is set up before the completing edge; nibbles ride high
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && avs_waitrequest) begin
			if (bus_width_select || !mapped) begin
				avs_readdata <= {24'h00_0000, rbyte};
			end else if (!nib_second) begin
				avs_readdata <= {24'h00_0000, rbyte[7:4], 4'h0};
			end else begin
				avs_readdata <= {24'h00_0000, hold_lo, 4'h0};
			end
		end
	end

	// Nibble pairing; a width change restarts the pair
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			nib_second <= 1'b0;
			hi_nib <= 4'h0;
			hold_lo <= 4'h0;
		end else if (op_func) begin
			nib_second <= 1'b0;
		end else if (!bus_width_select && acc && mapped
			&& (avs_read || avs_byteenable[0])) begin
			nib_second <= !nib_second;
			if (!nib_second) begin
				hi_nib <= avs_writedata[7:4];
				hold_lo <= rbyte[3:0];
			end
		end
	end

	// Function setup and entry mode configuration
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			bus_width_select <= 1'b1;
			cfg_two_line <= 1'b0;
			cfg_font_tall <= 1'b0;
			entry_increment <= 1'b1;
			write_scroll_enable <= 1'b0;
		end else if (op_func) begin
			bus_width_select <= wbyte[clie_pkg::B_WIDTH];
			cfg_two_line <= wbyte[clie_pkg::B_LINES];
			cfg_font_tall <= wbyte[clie_pkg::B_FONT];
		end else if (op_entry) begin
			entry_increment <= wbyte[clie_pkg::B_INC];
			write_scroll_enable <= wbyte[clie_pkg::B_SCROLL];
		end else if (op_clear) begin
			entry_increment <= 1'b1;
		end
	end

	// Address counter and memory target
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			address_pointer <= 7'h00;
			glyph_sel <= 1'b0;
		end else begin
			address_pointer <= next_ptr;
			glyph_sel <= next_glyph;
		end
	end

	// Prefetch register; writes leave it alone, so a read after a
	// write still sees the older byte
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			out_data <= 8'h00;
		end else if (op_text || op_glyph || ex_rd
			|| (cursor_move && !glyph_sel)) begin
			out_data <= pf_byte;
		end
	end

	// Display shift: one offset for all lines, no memory touched
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			disp_offset <= 7'h00;
		end else if (op_home || op_clear || op_func) begin
			disp_offset <= 7'h00;
		end else if (disp_move) begin
			disp_offset <= clie_rot(disp_offset,
				!wbyte[clie_pkg::B_RL], cfg_two_line);
		end else if (scroll_wr) begin
			disp_offset <= clie_rot(disp_offset, entry_increment,
				cfg_two_line);
		end
	end

	// Memory storage; no reset, contents are data not control
	always_ff @(posedge sys_clk) begin
		if (op_clear) begin
			for (int i = 0; i < clie_pkg::TXT_DEPTH; i++) begin
				text_mem[i] <= clie_pkg::SPACE_CODE;
			end
		end else if (dwr && !glyph_sel
			&& wr_idx < clie_pkg::TXT_DEPTH) begin
			text_mem[wr_idx] <= wbyte;
		end
		if (dwr && glyph_sel) begin
			glyph_mem[address_pointer[5:0]] <= wbyte;
		end
	end

	// Busy sequencer; restarting while busy is tolerated
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state <= clie_pkg::ST_IDLE;
			busy_cnt <= '0;
			busy_indicator <= 1'b0;
		end else if (ins || dwr || ex_rd) begin
			state <= clie_pkg::ST_BUSY;
			busy_cnt <= clie_pkg::CNT_W'(busy_cycles - 1'b1);
			busy_indicator <= 1'b1;
		end else begin
			unique case (state)
			clie_pkg::ST_IDLE: begin
				busy_indicator <= 1'b0;
			end
			clie_pkg::ST_BUSY: begin
				if (busy_cnt == '0) begin
					state <= clie_pkg::ST_IDLE;
					busy_indicator <= 1'b0;
				end else begin
					busy_cnt <= busy_cnt - 1'b1;
				end
			end
			default: begin
				state <= clie_pkg::ST_IDLE;
				busy_indicator <= 1'b0;
			end
			endcase
		end
	end

	// Refresh reads; codes above 0Fh have no glyph here
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			refresh_char <= 8'h00;
			refresh_pixels <= 5'h00;
		end else begin
			refresh_char <= 8'h00;
			if (clie_tidx(refresh_text_addr, cfg_two_line)
				< clie_pkg::TXT_DEPTH) begin
				refresh_char <= text_mem[clie_tidx(refresh_text_addr,
					cfg_two_line)];
			end
			refresh_pixels <= (refresh_code[7:4] == 4'h0)
				? glyph_mem[{refresh_code[2:0], refresh_row}][4:0]
				: 5'h00;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence s_status_setup;
		avs_read && avs_waitrequest && bus_width_select
			&& avs_address == clie_pkg::REG_CTRL;
	endsequence

	property p_cursor_step;
		cursor_move |=> address_pointer == $past(stepped);
	endproperty
	a_cursor_step: assert property (p_cursor_step)
		else $error("cursor shift did not step pointer");

	property p_line_wrap;
		(cursor_move && wbyte[clie_pkg::B_RL] && cfg_two_line
			&& !glyph_sel && address_pointer == clie_pkg::TXT_L1_END)
			|=> address_pointer == clie_pkg::TXT_L2_BASE;
	endproperty
	a_line_wrap: assert property (p_line_wrap)
		else $error("cursor did not wrap to second line");

	property p_disp_shift;
		disp_move |=> $stable(address_pointer)
			&& disp_offset != $past(disp_offset);
	endproperty
	a_disp_shift: assert property (p_disp_shift)
		else $error("display shift touched pointer or kept offset");

	property p_func_set;
		op_func |=> bus_width_select == $past(wbyte[clie_pkg::B_WIDTH])
			&& cfg_two_line == $past(wbyte[clie_pkg::B_LINES])
			&& cfg_font_tall == $past(wbyte[clie_pkg::B_FONT]);
	endproperty
	a_func_set: assert property (p_func_set)
		else $error("function setup not applied");

	property p_text_addr;
		op_text |=> address_pointer == $past(wbyte[6:0]) && !glyph_sel;
	endproperty
	a_text_addr: assert property (p_text_addr)
		else $error("text address not loaded");

	property p_glyph_addr;
		op_glyph |=> address_pointer == {1'b0, $past(wbyte[5:0])}
			&& glyph_sel;
	endproperty
	a_glyph_addr: assert property (p_glyph_addr)
		else $error("glyph address not loaded");

	property p_status;
		s_status_setup |=> avs_readdata[7:0]
			== {$past(busy_indicator), $past(address_pointer)}
			&& !avs_waitrequest;
	endproperty
	a_status: assert property (p_status)
		else $error("status read wrong");

	property p_write_step;
		dwr |=> address_pointer == $past(stepped) && $stable(out_data);
	endproperty
	a_write_step: assert property (p_write_step)
		else $error("data write did not step or changed prefetch");

	property p_read_step;
		ex_rd |=> address_pointer == $past(stepped);
	endproperty
	a_read_step: assert property (p_read_step)
		else $error("data read did not step pointer");

	property p_nibble_hold;
		(acc && avs_write && avs_byteenable[0] && mapped
			&& !bus_width_select && !nib_second)
			|=> nib_second && $stable(address_pointer);
	endproperty
	a_nibble_hold: assert property (p_nibble_hold)
		else $error("first nibble acted alone");

	property p_busy_hold;
		(ins || dwr) |=> busy_indicator [*3];
	endproperty
	a_busy_hold: assert property (p_busy_hold)
		else $error("busy flag dropped early");
endmodule
`default_nettype wire

// File: test/clie_host.sv
// Purpose: Host processor model that drives the engine over Avalon-MM.
// Assumes: The engine answers every access by dropping waitrequest.
// Notes: Keeps its own copy of the transfer width so nibbles stay paired.
`timescale 1ns/10ps
`default_nettype none
module clie_host (
	input wire logic sys_clk,             // System clock
	output logic [2:0] avs_address,       // Byte address
	output logic avs_read,                // Read request
	output logic avs_write,               // Write request
	output logic [3:0] avs_byteenable,    // Byte lanes
	output logic [31:0] avs_writedata,    // Write data
	input wire logic [31:0] avs_readdata, // Read data
	input wire logic avs_waitrequest      // Stall
);
	logic four_bit = 1'b0; // Host copy of the width
	logic [3:0] be = 4'hF; // Lanes for the next access
	// Quiet bus at time zero
	initial begin
		avs_address = 3'h7;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_byteenable = 4'hF;
		avs_writedata = 32'h0;
	end
	// One access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [2:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_read <= ~wr;
		avs_write <= wr;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge sys_clk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// Released lines must not keep showing the last value
		avs_writedata <= ~d;
		avs_address <= ~a;
	endtask
	// One byte; in 4-bit mode high nibble first on [7:4]
	task automatic xfer(input logic wr, input logic [2:0] a,
		input logic [7:0] b, output logic [7:0] r);
		logic [31:0] q;
		logic [31:0] q2;
		if (four_bit) begin
			bus(wr, a, {24'h0, b[7:4], 4'h0}, q);
			bus(wr, a, {24'h0, b[3:0], 4'h0}, q2);
			r = {q[7:4], q2[7:4]};
		end else begin
			bus(wr, a, {24'h0, b}, q);
			r = q[7:0];
		end
	endtask
	// Poll status until the busy indicator drops
	task automatic wait_idle();
		logic [7:0] s;
		s = 8'h80;
		while (s[7] !== 1'b0)
			xfer(1'b0, clie_pkg::REG_CTRL, 8'h00, s);
	endtask
	// Instruction; a function set also changes our width
	task automatic instr(input logic [7:0] b);
		logic [7:0] r;
		wait_idle();
		xfer(1'b1, clie_pkg::REG_CTRL, b, r);
		if (b[7:5] == 3'b001)
			four_bit = ~b[4];
	endtask
	// Data accesses also wait for the engine first
	task automatic wr_data(input logic [7:0] b);
		logic [7:0] r;
		wait_idle();
		xfer(1'b1, clie_pkg::REG_DATA, b, r);
	endtask
	task automatic rd_data(output logic [7:0] r);
		wait_idle();
		xfer(1'b0, clie_pkg::REG_DATA, 8'h00, r);
	endtask
endmodule
`default_nettype wire

// File: test/clie_top_bench.sv
// Purpose: Self-checking bench for the instruction engine.
// Assumes: Short busy time so polling loops stay brief.
// Notes: Table of instructions first, then data and width cases.
`timescale 1ns/10ps
`default_nettype none
module clie_top_bench;
	typedef struct packed {
		logic [7:0] ins;
		logic [6:0] ptr;
		logic [6:0] off;
		logic [4:0] cfg; // width, two-line, tall, increment, scroll
	} clie_row_t;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [2:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [6:0] refresh_text_addr = 7'h00;
	logic [7:0] refresh_code = 8'h00;
	logic [2:0] refresh_row = 3'h0;
	logic [7:0] refresh_char;
	logic [4:0] refresh_pixels;
	logic bus_width_select, cfg_two_line, cfg_font_tall;
	logic entry_increment, write_scroll_enable, busy_indicator;
	logic [6:0] disp_offset, address_pointer;
	logic [7:0] r;
	logic [31:0] q;
	int n_fail = 0;
	int checked = 0;
	int cycles = 0;
	// Boundary moves: line ends, wraps and every shift direction
	clie_row_t rows [18] = '{
		'{8'h90, 7'h10, 7'h00, 5'b10010}, '{8'h14, 7'h11, 7'h00, 5'b10010},
		'{8'h10, 7'h10, 7'h00, 5'b10010}, '{8'h18, 7'h10, 7'h01, 5'b10010},
		'{8'h1C, 7'h10, 7'h00, 5'b10010}, '{8'h38, 7'h10, 7'h00, 5'b11010},
		'{8'hA7, 7'h27, 7'h00, 5'b11010}, '{8'h14, 7'h40, 7'h00, 5'b11010},
		'{8'h10, 7'h27, 7'h00, 5'b11010}, '{8'h1C, 7'h27, 7'h27, 5'b11010},
		'{8'h3C, 7'h27, 7'h00, 5'b11110}, '{8'h34, 7'h27, 7'h00, 5'b10110},
		'{8'hCF, 7'h4F, 7'h00, 5'b10110}, '{8'h14, 7'h00, 7'h00, 5'b10110},
		'{8'h45, 7'h05, 7'h00, 5'b10110}, '{8'h04, 7'h05, 7'h00, 5'b10100},
		'{8'h07, 7'h05, 7'h00, 5'b10111}, '{8'h06, 7'h05, 7'h00, 5'b10110}};

	always #2.5 sys_clk = ~sys_clk;

	clie_top #(.busy_cycles(13'd6)) dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_byteenable(avs_byteenable),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.refresh_text_addr(refresh_text_addr),
		.refresh_code(refresh_code), .refresh_row(refresh_row),
		.refresh_char(refresh_char), .refresh_pixels(refresh_pixels),
		.bus_width_select(bus_width_select), .cfg_two_line(cfg_two_line),
		.cfg_font_tall(cfg_font_tall), .entry_increment(entry_increment),
		.write_scroll_enable(write_scroll_enable),
		.disp_offset(disp_offset), .address_pointer(address_pointer),
		.busy_indicator(busy_indicator));

	clie_host host (
		.sys_clk(sys_clk), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	// Compare and count; four-state so unknowns never match
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Hang guard, far above the several hundred cycles the run needs
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end

	initial begin
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		#1;
		check("waitreq", avs_waitrequest, 1'b1);
		check("readdata", avs_readdata, 32'h0);
		check("cfg", {bus_width_select, cfg_two_line, cfg_font_tall,
			entry_increment, write_scroll_enable}, 5'b10010);
		check("rst ptr", {busy_indicator, disp_offset, address_pointer}, 15'h0);
		host.rd_data(r);
		check("first read", r, 8'h00);
		// Instruction table: decode, pointer, offset, setup bits
		foreach (rows[i]) begin
			host.instr(rows[i].ins);
			#1;
			check("busy", busy_indicator, 1'b1);
			check("ptr", address_pointer, rows[i].ptr);
			check("offset", disp_offset, rows[i].off);
			check("cfg", {bus_width_select, cfg_two_line, cfg_font_tall,
				entry_increment, write_scroll_enable}, rows[i].cfg);
			host.xfer(1'b0, clie_pkg::REG_CTRL, 8'h00, r);
			check("status", r, {1'b1, rows[i].ptr});
		end
		// Writes step the pointer; the next read gives the old prefetch
		host.instr(8'h01);
		host.instr(8'h80);
		host.wr_data(8'h41);
		host.wr_data(8'h42);
		#1 check("wr ptr", address_pointer, 7'h02);
		host.rd_data(r);
		check("stale", r, 8'h20);
		#1 check("rd ptr", address_pointer, 7'h03);
		host.instr(8'h80);
		host.rd_data(r);
		check("rd0", r, 8'h41);
		host.rd_data(r);
		check("rd1", r, 8'h42);
		host.instr(8'h80);
		host.instr(8'h14);
		host.rd_data(r);
		check("shift pf", r, 8'h42);
		@(posedge sys_clk);
		refresh_text_addr <= 7'h01;
		refresh_code <= 8'h08;
		@(posedge sys_clk);
		#1 check("refresh", refresh_char, 8'h42);
		// Decrement, then text write scroll, glyph write no scroll
		host.instr(8'h04);
		host.instr(8'h85);
		host.wr_data(8'h55);
		#1 check("dec ptr", address_pointer, 7'h04);
		host.instr(8'h07);
		host.wr_data(8'h43);
		#1 check("scroll", disp_offset, 7'h01);
		host.instr(8'h40);
		host.wr_data(8'h1F);
		#1 check("gly ptr", {disp_offset, address_pointer}, 14'h81);
		repeat (2) @(posedge sys_clk);
		#1 check("pixels", refresh_pixels, 5'h1F);
		// Second glyph row, then a code with no glyph behind it
		host.wr_data(8'h0A);
		refresh_row <= 3'h1;
		repeat (2) @(posedge sys_clk);
		#1 check("row1", refresh_pixels, 5'h0A);
		@(posedge sys_clk);
		refresh_code <= 8'h10;
		repeat (2) @(posedge sys_clk);
		#1 check("no glyph", refresh_pixels, 5'h00);
		// A text read does not shift the display, even with scroll on
		host.instr(8'h80);
		host.rd_data(r);
		#1 check("rd noscroll", disp_offset, 7'h01);
		// Disabled lane changes nothing; unmapped address reads zero
		host.be = 4'hE;
		host.instr(8'h90);
		host.be = 4'hF;
		#1 check("lane off", address_pointer, 7'h01);
		host.bus(1'b0, 3'h2, 32'h0, q);
		check("unmapped", q, 32'h0);
		// 4-bit mode: only the second nibble acts
		host.instr(8'h28);
		#1 check("width4", {bus_width_select, cfg_two_line}, 2'b01);
		host.wait_idle();
		host.bus(1'b1, clie_pkg::REG_CTRL, 32'hC0, q);
		#1 check("half", address_pointer, 7'h01);
		host.bus(1'b1, clie_pkg::REG_CTRL, 32'h10, q);
		#1 check("whole", address_pointer, 7'h41);
		host.wait_idle();
		host.xfer(1'b0, clie_pkg::REG_CTRL, 8'h00, r);
		check("st4", r, 8'h41);
		host.wr_data(8'h5A);
		host.instr(8'hC1);
		host.rd_data(r);
		check("rd4", r, 8'h5A);
		host.instr(8'h38);
		#1 check("width8", bus_width_select, 1'b1);
		// Reset in mid-run drops two-line, scroll and busy again
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		#1 check("mid rst", {bus_width_select, cfg_two_line,
			cfg_font_tall, entry_increment, write_scroll_enable,
			busy_indicator, address_pointer}, 13'h1200);
		host.xfer(1'b0, clie_pkg::REG_CTRL, 8'h00, r);
		check("rst status", r, 8'h00);
		report_and_stop();
	end
endmodule
`default_nettype wire
